// ### logic/disk_ctrl_pkg.sv
package disk_ctrl_pkg;
   typedef logic [15:0] word_t;
   typedef logic [2:0] word_sel_t;
   typedef logic [19:0] mem_addr_t;
   typedef enum {ST_IDLE, ST_CHECK, ST_RUN} ctrl_state_t;

   // Word indices on the host word port
   localparam word_sel_t WORD_SECTOR = 3'h2;
   localparam word_sel_t WORD_CYLINDER = 3'h3;
   localparam word_sel_t WORD_COUNT = 3'h4;
   localparam word_sel_t WORD_ADDR_LOW = 3'h5;
   localparam word_sel_t WORD_UNIT_ADDR_HIGH = 3'h6;
   localparam word_sel_t WORD_STATUS = 3'h7;

   // Status word bit positions (documented bit n sits at vector bit 15-n)
   localparam int SB_IDLE = 15;
   localparam int SB_COMPLETE = 14;
   localparam int SB_ERROR = 13;
   localparam int SB_INT_EN = 12;
   localparam int SB_LOCKOUT = 11;
   localparam int SB_MEM_FAULT = 7;
   localparam int SB_BUS_TIMEOUT = 5;
   localparam int SB_CMD_TIMEOUT = 2;
   localparam int SB_UNIT_FAULT = 0;
   localparam word_t STATUS_RST = 16'h8000;
   localparam word_t ERR_MASK = 16'h01ff;
   localparam word_t ENG_MASK = 16'h07ff;
   localparam logic [7:0] SELFTEST_FAIL_BYTE = 8'hff;

   // Field layout
   localparam int SECTOR_LSB = 0;
   localparam int SECTOR_W = 8;
   localparam logic [7:0] SECTOR_MAX = 8'h3c;
   localparam word_t CYLINDER_MAX = 16'h032c;
   localparam int USEL_LSB = 8;
   localparam int USEL_W = 4;
   localparam int ADDR_LO_W = 15;
   localparam int ADDR_HI_W = 5;
   localparam word_t WORD_RST = 16'h0000;

   // Bus cycle timer: longest time, rounded down
   localparam int CLK_PERIOD_NS = 100;
   localparam int BUS_TIMEOUT_NS = 12000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;

   localparam int FIFO_DEPTH = 16;
endpackage

// ### logic/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 16) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### logic/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Streams
   stream_if.snk inS,
   stream_if.src outS
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [CW-1:0] cnt_r;
   logic push;
   logic pop;

   assign inS.ready = (cnt_r != FULL_CNT);
   assign outS.valid = (cnt_r != '0);
   assign outS.data = mem[rdPtr_r];
   assign push = inS.valid && inS.ready;
   assign pop = outS.valid && outS.ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inS.data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // stream_fifo

// ### logic/bus_cycle_timer.sv
`timescale 1ns/1ps
module bus_cycle_timer #(
   parameter int LIMIT = 120
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Cycle watch
   input wire logic active,
   output logic expired
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
   logic [CW-1:0] cnt_r;

   // Fires in the LIMIT-th cycle that a bus cycle stays open
   assign expired = active && (cnt_r == LAST);

   always_ff @(posedge clk) begin
      if (!rstn || !active) begin
         cnt_r <= '0;
      end else if (!expired) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule // bus_cycle_timer

// ### logic/disk_ctrl_command_status_words.sv
// How it works
// - Upper byte of sector word is stored but never used by hardware.
// - Low byte of sector word is the start sector, valid 00 to 3C.
// - Start sector above 3C ends a transfer command with command time-out.
// - Self-test failure sets status low byte to FF and code in sector word.
// - Cylinder word is seek target, readable, updated and holds test number.
// - Cylinder above 032C terminates and sets unit fault.
// - Transfer to missing memory reports bus time-out.
// - Suppressed read drains disk data without any memory write.
// - 20-bit buffer address split over low word and unit word low bits.
// - Address counts up; after memory fault it reads fault address plus 2.
// - Device masters the memory bus, stepping through the word count.
// - Unit select is one-hot; other patterns give offline and no operation.
// - Host writes and status reads are honoured only while idle.
// - Writing status with idle bit zero starts the operation.
// - Complete bit set on clean finish; host may clear it.
// - Error bit set on any error, details in status bits.
// - Interrupt while idle, enabled and complete or error.
// - Lockout set on first status read, cleared at reset and command end.
// - Retry and ECC corrected bits reported from the last operation.
// - Self-test failure bits stay set and block commands until reset.
// - Each bus cycle bounded by 12 us; expiry aborts and sets bus time-out.
`timescale 1ns/1ps
module disk_ctrl_command_status_words
   import disk_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Host word port
   input wire disk_ctrl_pkg::word_sel_t regSel,
   input wire logic regWr,
   input wire logic regRd,
   input wire disk_ctrl_pkg::word_t regWdata,
   output disk_ctrl_pkg::word_t regRdata,
   output logic cmdIrq,
   // Memory bus master
   output logic memReq,
   output logic memWe,
   output disk_ctrl_pkg::mem_addr_t memAddr,
   output disk_ctrl_pkg::word_t memWdata,
   input wire disk_ctrl_pkg::word_t memRdata,
   input wire logic memAck,
   input wire logic memErr,
   // Disk read data into the buffer
   input wire logic diskInValid,
   input wire disk_ctrl_pkg::word_t diskInData,
   output logic diskInReady,
   // Disk write data out
   output logic diskOutValid,
   output disk_ctrl_pkg::word_t diskOutData,
   input wire logic diskOutReady,
   // Command engine
   input wire logic cmdToDisk,
   input wire logic cmdXfer,
   input wire logic suppressTransfer,
   input wire logic engDone,
   input wire disk_ctrl_pkg::word_t engStatus,
   input wire logic engPosLoad,
   input wire disk_ctrl_pkg::word_t engSector,
   input wire disk_ctrl_pkg::word_t engCylinder,
   input wire logic stFail,
   input wire disk_ctrl_pkg::word_t stCode,
   output logic opStart,
   output logic opAbort,
   output logic [3:0] unitSel,
   output logic unitOffline,
   output disk_ctrl_pkg::word_t startSector,
   output disk_ctrl_pkg::word_t seekCylinder
);
   import disk_ctrl_pkg::*;

   ctrl_state_t state_r;
   word_t sector_r;
   word_t cyl_r;
   word_t count_r;
   word_t status_r;
   mem_addr_t addr_r;
   logic [USEL_W-1:0] usel_r;
   logic [14:0] xferLeft_r;
   logic selfFail_r;
   logic engSeen_r;
   logic memReq_r;
   logic memWe_r;
   word_t memWdata_r;
   logic outValid_r;
   word_t outData_r;
   word_t rdata_r;
   logic irq_r;
   logic opStart_r;
   logic opAbort_r;
   logic offline_r;

   logic wrOk;
   logic startReq;
   logic unitOk;
   logic badCyl;
   logic badSec;
   logic tmoExpire;
   logic finish;
   logic finErr;
   logic launch;
   word_t finFlags;

   stream_if #(.WIDTH(16)) diskS ();
   stream_if #(.WIDTH(16)) dmaS ();

   assign diskS.valid = diskInValid;
   assign diskS.data = diskInData;
   assign diskInReady = diskS.ready;

   // Disk side keeps running while the bus is slow; the buffer absorbs up to 16 words, then refuses
   stream_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rstn(rstn),
      .inS(diskS),
      .outS(dmaS)
   );

   bus_cycle_timer #(.LIMIT(BUS_TIMEOUT_CYC)) u_tmo (
      .clk(sys_clk),
      .rstn(rstn),
      .active(memReq_r),
      .expired(tmoExpire)
   );

   assign wrOk = regWr && status_r[SB_IDLE];
   assign startReq = wrOk && (regSel == WORD_STATUS) &&
      !regWdata[SB_IDLE];
   assign unitOk = $onehot(usel_r);
   assign badCyl = (cyl_r > CYLINDER_MAX);
   assign badSec = cmdXfer &&
      (sector_r[SECTOR_LSB +: SECTOR_W] > SECTOR_MAX);
   assign launch = (state_r == ST_RUN) && !finish && !memReq_r &&
      (xferLeft_r != '0);
   // Pops when a word is captured or discarded; idle drains what a cut
   // command left behind so it never leaks into the next transfer
   assign dmaS.ready = (launch && !cmdToDisk) || (state_r == ST_IDLE);

   always_comb begin
      finFlags = '0;
      finish = 1'b0;
      case (state_r)
         ST_CHECK: begin
            if (selfFail_r) begin
               finFlags[SB_ERROR] = 1'b1;
            end else if (!unitOk || badCyl) begin
               finFlags[SB_UNIT_FAULT] = 1'b1;
            end else if (badSec) begin
               finFlags[SB_CMD_TIMEOUT] = 1'b1;
            end
            finish = selfFail_r || !unitOk || badCyl || badSec;
         end
         ST_RUN: begin
            if (memReq_r && memErr) begin
               finFlags[SB_MEM_FAULT] = 1'b1;
            end
            if (tmoExpire) begin
               finFlags[SB_BUS_TIMEOUT] = 1'b1;
            end
            if (engDone) begin
               finFlags = finFlags | (engStatus & ENG_MASK);
            end
            finish = |(finFlags & ERR_MASK) ||
               (engSeen_r && (xferLeft_r == '0) && !memReq_r &&
               !outValid_r);
         end
         default: begin
         end
      endcase
   end

   assign finErr = |((status_r | finFlags) & ERR_MASK) || selfFail_r;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (startReq) begin
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               state_r <= finish ? ST_IDLE : ST_RUN;
            end
            ST_RUN: begin
               if (finish) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Status word: host write first, hardware events after so a set wins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         status_r <= STATUS_RST;
      end else begin
         if (wrOk && (regSel == WORD_STATUS)) begin
            status_r <= regWdata;
            status_r[SB_LOCKOUT] <= status_r[SB_LOCKOUT];
            if (selfFail_r) begin
               status_r[7:0] <= SELFTEST_FAIL_BYTE;
            end
         end
         if (regRd && (regSel == WORD_STATUS)) begin
            status_r[SB_LOCKOUT] <= 1'b1;
         end
         if (state_r == ST_RUN) begin
            status_r <= status_r | finFlags;
         end
         if (finish) begin
            status_r <= status_r | finFlags;
            status_r[SB_IDLE] <= 1'b1;
            status_r[SB_LOCKOUT] <= 1'b0;
            status_r[SB_COMPLETE] <= !finErr;
            status_r[SB_ERROR] <= finErr;
         end
         if (stFail) begin
            status_r[7:0] <= SELFTEST_FAIL_BYTE;
            status_r[SB_ERROR] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         selfFail_r <= 1'b0;
      end else if (stFail) begin
         selfFail_r <= 1'b1;
      end
   end

   // Sector and cylinder words; whole upper byte of sector is kept only
   // for read-back since one sector is always one record
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sector_r <= WORD_RST;
         cyl_r <= WORD_RST;
         count_r <= WORD_RST;
         usel_r <= '0;
      end else begin
         if (wrOk && (regSel == WORD_SECTOR)) begin
            sector_r <= regWdata;
         end
         if (wrOk && (regSel == WORD_CYLINDER)) begin
            cyl_r <= regWdata;
         end
         if (wrOk && (regSel == WORD_COUNT)) begin
            count_r <= regWdata;
         end
         if (wrOk && (regSel == WORD_UNIT_ADDR_HIGH)) begin
            usel_r <= regWdata[USEL_LSB +: USEL_W];
         end
         if (engPosLoad) begin
            sector_r <= engSector;
            cyl_r <= engCylinder;
         end
         if (stFail) begin
            sector_r <= stCode;
         end
      end
   end

   // Bus master: address, remaining words and the bus cycle
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         addr_r <= '0;
         xferLeft_r <= '0;
         memReq_r <= 1'b0;
         memWe_r <= 1'b0;
         memWdata_r <= WORD_RST;
      end else begin
         if (wrOk && (regSel == WORD_ADDR_LOW)) begin
            addr_r[ADDR_LO_W-1:0] <= regWdata[15:1];
         end
         if (wrOk && (regSel == WORD_UNIT_ADDR_HIGH)) begin
            addr_r[19:ADDR_LO_W] <= regWdata[ADDR_HI_W-1:0];
         end
         if (state_r == ST_CHECK) begin
            xferLeft_r <= cmdXfer ? count_r[15:1] : '0;
         end
         if (memReq_r && (memAck || memErr)) begin
            memReq_r <= 1'b0;
            addr_r <= addr_r + 1'b1;
         end else if (finish) begin
            memReq_r <= 1'b0;
         end else if (launch) begin
            if (cmdToDisk) begin
               if (!outValid_r) begin
                  memReq_r <= 1'b1;
                  memWe_r <= 1'b0;
                  xferLeft_r <= xferLeft_r - 1'b1;
               end
            end else if (dmaS.valid) begin
               xferLeft_r <= xferLeft_r - 1'b1;
               if (!suppressTransfer) begin
                  memReq_r <= 1'b1;
                  memWe_r <= 1'b1;
                  memWdata_r <= dmaS.data;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         outValid_r <= 1'b0;
         outData_r <= WORD_RST;
      end else if (memReq_r && memAck && !memWe_r) begin
         outValid_r <= 1'b1;
         outData_r <= memRdata;
      end else if (diskOutReady || state_r != ST_RUN) begin
         outValid_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         engSeen_r <= 1'b0;
         opStart_r <= 1'b0;
         opAbort_r <= 1'b0;
         offline_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         if (state_r == ST_CHECK) begin
            engSeen_r <= 1'b0;
         end else if (engDone && state_r == ST_RUN) begin
            engSeen_r <= 1'b1;
         end
         opStart_r <= (state_r == ST_CHECK) && !finish;
         opAbort_r <= (state_r == ST_RUN) && finish && finErr;
         offline_r <= !unitOk;
         irq_r <= status_r[SB_IDLE] && status_r[SB_INT_EN] &&
            (status_r[SB_COMPLETE] || status_r[SB_ERROR]);
      end
   end

   // Busy: only the idle bit is visible, everything else reads zero
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata_r <= WORD_RST;
      end else if (regRd) begin
         rdata_r <= WORD_RST;
         if (!status_r[SB_IDLE]) begin
            rdata_r[SB_IDLE] <= 1'b0;
         end else if (regSel == WORD_SECTOR) begin
            rdata_r <= sector_r;
         end else if (regSel == WORD_CYLINDER) begin
            rdata_r <= cyl_r;
         end else if (regSel == WORD_COUNT) begin
            rdata_r <= count_r;
         end else if (regSel == WORD_ADDR_LOW) begin
            rdata_r <= {addr_r[ADDR_LO_W-1:0], 1'b0};
         end else if (regSel == WORD_UNIT_ADDR_HIGH) begin
            rdata_r <= {4'h0, usel_r, 3'h0, addr_r[19:ADDR_LO_W]};
         end else if (regSel == WORD_STATUS) begin
            rdata_r <= status_r;
         end
      end
   end

   assign regRdata = rdata_r;
   assign cmdIrq = irq_r;
   assign memReq = memReq_r;
   assign memWe = memWe_r;
   assign memAddr = addr_r;
   assign memWdata = memWdata_r;
   assign diskOutValid = outValid_r;
   assign diskOutData = outData_r;
   assign opStart = opStart_r;
   assign opAbort = opAbort_r;
   assign unitSel = usel_r;
   assign unitOffline = offline_r;
   assign startSector = sector_r;
   assign seekCylinder = cyl_r;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_check_bad_cyl;
      state_r == ST_CHECK && !selfFail_r && badCyl;
   endsequence
   sequence s_check_bad_sec;
      state_r == ST_CHECK && !selfFail_r && unitOk && !badCyl && badSec;
   endsequence

   AST_START_BUSY: assert property (
      startReq |=> !status_r[SB_IDLE] && state_r == ST_CHECK)
      else $error("start write did not make the block busy");
   AST_BUSY_HOLD: assert property (
      regWr && !status_r[SB_IDLE] && !engPosLoad && !stFail
      |=> $stable(sector_r) && $stable(cyl_r) && $stable(count_r))
      else $error("control word changed by a write while busy");
   AST_CYL_FAULT: assert property (
      s_check_bad_cyl |=> status_r[SB_UNIT_FAULT] && status_r[SB_IDLE]
      && status_r[SB_ERROR] && !opStart)
      else $error("bad cylinder did not end with unit fault");
   AST_SEC_TIMEOUT: assert property (
      s_check_bad_sec |=> status_r[SB_CMD_TIMEOUT] && status_r[SB_IDLE])
      else $error("bad sector did not end with command time-out");
   AST_IRQ: assert property (
      status_r[SB_IDLE] && status_r[SB_INT_EN] && status_r[SB_COMPLETE]
      |=> cmdIrq)
      else $error("completion interrupt missing");
   AST_LOCKOUT: assert property (
      regRd && regSel == WORD_STATUS && state_r == ST_IDLE
      |=> status_r[SB_LOCKOUT])
      else $error("lockout not set by status read");
   AST_BUS_TIMEOUT: assert property (
      memReq_r && !memAck && !memErr && state_r == ST_RUN
      ##1 (memReq_r && !memAck && !memErr) [*8]
      |-> ##[0:120] status_r[SB_BUS_TIMEOUT] || !memReq_r)
      else $error("stuck bus cycle not bounded");
   AST_FAULT_ADDR: assert property (
      memReq_r && memErr |=> addr_r == $past(addr_r) + 20'h00001)
      else $error("address not stepped past the faulting word");
   AST_SELFTEST: assert property (
      stFail |=> status_r[7:0] == SELFTEST_FAIL_BYTE
      && sector_r == $past(stCode))
      else $error("self-test failure not reported");
   AST_SUPPRESS: assert property (
      state_r == ST_RUN && suppressTransfer && !cmdToDisk && !memReq_r
      |=> !memReq_r)
      else $error("memory written during suppressed read");
endmodule // disk_ctrl_command_status_words

// ### test/mem_model.sv
`timescale 1ns/1ps
module mem_model
   import disk_ctrl_pkg::*;
#(
   parameter mem_addr_t FAULT_ADDR = 20'h00031
) (
   // Clock
   input wire logic clk,
   // Memory bus
   input wire logic memReq,
   input wire logic memWe,
   input wire disk_ctrl_pkg::mem_addr_t memAddr,
   input wire disk_ctrl_pkg::word_t memWdata,
   output disk_ctrl_pkg::word_t memRdata = 16'h0000,
   output logic memAck = 1'b0,
   output logic memErr = 1'b0,
   // Wait states per cycle
   input wire logic [3:0] latency
);
   word_t mem [64];
   logic [3:0] cnt = 4'h0;

   always @(posedge clk) begin
      memAck <= 1'b0;
      memErr <= 1'b0;
      // Idle data lines keep toggling so stale data never looks valid
      memRdata <= ~memRdata;
      // Top half of the space is absent and never answers
      if (memReq && !memAck && !memErr && !memAddr[19]) begin
         if (cnt != latency) begin
            cnt <= cnt + 4'h1;
         end else begin
            cnt <= 4'h0;
            memAck <= (memAddr != FAULT_ADDR);
            memErr <= (memAddr == FAULT_ADDR);
            memRdata <= mem[memAddr[5:0]];
            if (memWe) begin
               mem[memAddr[5:0]] <= memWdata;
            end
         end
      end
   end
endmodule // mem_model

// ### test/disk_ctrl_command_status_words_test.sv
`timescale 1ns/1ps
module disk_ctrl_command_status_words_test;
   import disk_ctrl_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   word_sel_t regSel = 3'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   word_t regWdata = 16'h0000;
   word_t regRdata, memWdata, memRdata, rv;
   logic cmdIrq, memReq, memWe, memAck, memErr, diskInReady;
   logic opStart, opAbort, unitOffline, diskOutValid;
   word_t diskOutData;
   word_t engStatus = 16'h0000;
   logic [31:0] outW = 32'h0;
   int aborts = 0;
   mem_addr_t memAddr;
   logic diskInValid = 1'b0;
   word_t diskInData = 16'h0000;
   logic cmdToDisk = 1'b0;
   logic cmdXfer = 1'b1;
   logic suppressTransfer = 1'b0;
   logic engDone = 1'b0;
   logic stFail = 1'b0;
   word_t stCode = 16'h0000;
   logic [3:0] memDelay = 4'h0;
   logic sawFull = 1'b0;
   int failures = 0;
   int tests_run = 0;
   int starts = 0;
   int reqs = 0;
   int r0 = 0;
   word_t tSec [3] = '{16'h013d, 16'h0101, 16'h0101};
   word_t tCyl [3] = '{16'h0000, 16'h032d, 16'h0000};
   word_t tUnit [3] = '{16'h0800, 16'h0800, 16'h0c00};
   word_t tFlag [3] = '{16'h0004, 16'h0001, 16'h0001};

   disk_ctrl_command_status_words dut (.sys_clk(sys_clk), .rstn(rstn),
      .regSel(regSel), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
      .regRdata(regRdata), .cmdIrq(cmdIrq), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
      .memAck(memAck), .memErr(memErr), .diskInValid(diskInValid),
      .diskInData(diskInData), .diskInReady(diskInReady),
      .diskOutValid(diskOutValid), .diskOutData(diskOutData),
      .diskOutReady(1'b1),
      .cmdToDisk(cmdToDisk), .cmdXfer(cmdXfer),
      .suppressTransfer(suppressTransfer), .engDone(engDone),
      .engStatus(engStatus), .engPosLoad(1'b0), .engSector(16'h0000),
      .engCylinder(16'h0000), .stFail(stFail), .stCode(stCode),
      .opStart(opStart), .opAbort(opAbort), .unitSel(),
      .unitOffline(unitOffline), .startSector(), .seekCylinder());

   mem_model partner (.clk(sys_clk), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
      .memAck(memAck), .memErr(memErr), .latency(memDelay));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (opStart === 1'b1) starts <= starts + 1;
      if (memReq === 1'b1) reqs <= reqs + 1;
      if (diskInValid && diskInReady === 1'b0) sawFull <= 1'b1;
      if (opAbort === 1'b1) aborts <= aborts + 1;
      if (diskOutValid === 1'b1) outW <= {outW[15:0], diskOutData};
   end

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input word_t got, input word_t exp, input string m);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input word_sel_t s, input word_t d);
      @(negedge sys_clk);
      regSel = s;
      regWdata = d;
      regWr = 1'b1;
      @(negedge sys_clk);
      regWr = 1'b0;
   endtask

   task automatic rd(input word_sel_t s, output word_t d);
      @(negedge sys_clk);
      regSel = s;
      regRd = 1'b1;
      @(negedge sys_clk);
      regRd = 1'b0;
      d = regRdata;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 300; i++) begin
         rd(WORD_STATUS, rv);
         if (rv[SB_IDLE] === 1'b1) return;
      end
      failures++;
      $display("ERROR %0t wait_idle timed out", $time);
   endtask

   task automatic load(word_t sec, word_t cyl, word_t cnt, word_t lo,
                       word_t hi);
      wr(WORD_SECTOR, sec);
      wr(WORD_CYLINDER, cyl);
      wr(WORD_COUNT, cnt);
      wr(WORD_ADDR_LOW, lo);
      wr(WORD_UNIT_ADDR_HIGH, hi);
      r0 = reqs;
      // Interrupt enable goes with the start, as the host should do it
      wr(WORD_STATUS, 16'h1000);
   endtask

   // Valid is held until an edge that samples ready high
   task automatic feed(input int n);
      logic ok;
      for (int i = 0; i < n; i++) begin
         diskInValid = 1'b1;
         diskInData = 16'ha500 + 16'(i);
         ok = 1'b0;
         while (!ok) begin
            ok = diskInReady;
            @(negedge sys_clk);
         end
      end
      diskInValid = 1'b0;
   endtask

   task automatic done_pulse(input word_t st);
      @(negedge sys_clk);
      engDone = 1'b1;
      engStatus = st;
      @(negedge sys_clk);
      engDone = 1'b0;
      engStatus = 16'h0000;
   endtask

   initial begin
      #4000000;
      failures++;
      complete_run();
   end

   initial begin
      repeat (12) @(negedge sys_clk);
      rstn = 1'b1;
      for (int s = 0; s < 7; s++) begin
         rd(word_sel_t'(s), rv);
         chk(rv, 16'h0000, "reset word");
      end
      rd(WORD_STATUS, rv);
      chk(rv & 16'hf7ff, STATUS_RST, "reset status");
      rd(WORD_STATUS, rv);
      chk(rv & 16'h0800, 16'h0800, "lockout");
      for (int k = 0; k < 3; k++) begin
         load(tSec[k], tCyl[k], 16'h0004, 16'h0000, tUnit[k]);
         wait_idle();
         chk(rv & 16'he0a5, 16'ha000 | tFlag[k], "refused");
         chk(16'(starts), 16'h0000, "no start");
         chk({15'h0, cmdIrq}, 16'h0001, "irq");
      end
      chk({15'h0, unitOffline}, 16'h0001, "offline");
      // Slow memory lets the buffer fill up and refuse
      memDelay = 4'h8;
      load(16'h013c, CYLINDER_MAX, 16'h0028, 16'h0020, 16'h0800);
      rd(WORD_STATUS, rv);
      chk(rv & 16'h8000, 16'h0000, "busy");
      wr(WORD_SECTOR, 16'h0107);
      feed(20);
      done_pulse(16'h0600);
      wait_idle();
      chk(rv & 16'he0a5, 16'hc000, "clean");
      chk(rv & 16'h0600, 16'h0600, "retry ecc");
      chk({15'h0, cmdIrq}, 16'h0001, "irq done");
      chk({15'h0, sawFull}, 16'h0001, "fifo full");
      for (int i = 0; i < 20; i++) begin
         chk(partner.mem[16 + i], 16'ha500 + 16'(i), "data");
      end
      rd(WORD_ADDR_LOW, rv);
      chk(rv, 16'h0048, "end addr");
      rd(WORD_SECTOR, rv);
      chk(rv, 16'h013c, "busy write");
      memDelay = 4'h0;
      load(16'h0101, 16'h0000, 16'h0008, 16'h0060, 16'h0800);
      feed(4);
      wait_idle();
      chk(rv & 16'he0a5, 16'ha080, "mem fault");
      rd(WORD_ADDR_LOW, rv);
      chk(rv, 16'h0064, "fault addr");
      load(16'h0101, 16'h0000, 16'h0002, 16'h0000, 16'h0810);
      feed(1);
      wait_idle();
      chk(rv & 16'he0a5, 16'ha020, "bus timeout");
      chk(16'(reqs - r0 >= 120 && reqs - r0 <= 122), 16'h0001, "tmo");
      chk(16'(aborts), 16'h0002, "abort");
      suppressTransfer = 1'b1;
      load(16'h0101, 16'h0000, 16'h0004, 16'h0000, 16'h0800);
      feed(2);
      done_pulse(16'h0000);
      wait_idle();
      chk(16'(reqs - r0), 16'h0000, "suppress");
      chk(rv & 16'he0a5, 16'hc000, "suppress done");
      suppressTransfer = 1'b0;
      cmdToDisk = 1'b1;
      load(16'h0101, 16'h0000, 16'h0004, 16'h0020, 16'h0800);
      done_pulse(16'h0000);
      wait_idle();
      chk(rv & 16'he0a5, 16'hc000, "write done");
      chk(outW[31:16], 16'ha500, "disk word 0");
      chk(outW[15:0], 16'ha501, "disk word 1");
      @(negedge sys_clk);
      stFail = 1'b1;
      stCode = 16'h5a3c;
      @(negedge sys_clk);
      stFail = 1'b0;
      rd(WORD_STATUS, rv);
      chk(rv & 16'h20ff, 16'h20ff, "self-test");
      rd(WORD_SECTOR, rv);
      chk(rv, 16'h5a3c, "fail code");
      r0 = starts;
      wr(WORD_STATUS, 16'h0000);
      wait_idle();
      chk(rv & 16'h00ff, 16'h00ff, "stays");
      chk(16'(starts - r0), 16'h0000, "inhibit");
      rstn = 1'b0;
      repeat (12) @(negedge sys_clk);
      rstn = 1'b1;
      rd(WORD_STATUS, rv);
      chk(rv & 16'hf7ff, STATUS_RST, "cleared");
      complete_run();
   end
endmodule // disk_ctrl_command_status_words_test
